/* File: core/eeprom_ctl.v */
// Instruction decode, status register and write protection of an SPI EEPROM
// Functional notes
// - Block-protect pair maps to none, top quarter, top half or whole array.
// - Protected blocks read-only; other writes and status need latch; hardware protect freezes status.
// - Sample input on rising serial clock while selected, MSB first, opcode first.
// - Output bits change on falling serial clock, MSB first.
// - Chip select rise ends transaction and starts writes; reads start once the address is in.
// - Decode set-latch, clear-latch and read-status opcodes without address.
// - Decode array read and array write with 24-bit address; status write takes no address.
// - Decode id-page read/lock-state and write/lock; address bit 10 selects.
// - Opcode bit 3 is ignored; an undefined opcode is ignored for the rest of the frame.
// - Array access uses address bits 17..0 only.
// - Id page uses address bits 7..0; lock uses bit 10 set.
// - Write-enable latch clear after reset.
// - Latch cleared by clear, status write, array write; set only by set.
// - Set-latch also accepted as 16-clock sequence.
// - Clear-latch also accepted as 16-clock sequence.
// - While busy only read-status is accepted.
// - Read-status repeats the status byte while selected.
// - Status write keeps only block-protect and protect-enable bits.
// - Status write ignored without latch or under hardware protection.
// - Status fields update only when the write cycle completes.
// - Protect enable may fall only while protect pin is high.
// - Status byte: busy, latch, block-protect pair, don't care, protect enable.
// - All status bits read one during a write cycle.
`timescale 1ns/1ps
`include "eeprom_ctl_consts.vh"
module eeprom_ctl #(
  parameter WRITE_CYCLES = `WRITE_CYCLE_NS / `CLK_PERIOD_NS
) (
  input wire core_clk,
  input wire rst_b,
  input wire cs_b,
  input wire sck,
  input wire si,
  input wire wp_b,
  output reg so_ff,
  output reg so_oe_ff,
  output wire [7:0] status,
  output reg [17:0] arr_addr_ff,
  output reg [7:0] id_index_ff,
  output reg arr_rd_start_ff,
  output reg arr_wr_start_ff,
  output reg id_rd_start_ff,
  output reg id_wr_start_ff,
  output reg id_lock_start_ff,
  output reg lock_rd_start_ff,
  output reg [7:0] wr_data_ff,
  output wire busy
);
  localparam S_OPC = 5'b00001;
  localparam S_ADDR = 5'b00010;
  localparam S_DATA = 5'b00100;
  localparam S_OUT = 5'b01000;
  localparam S_IGN = 5'b10000;

  ////////////////////////////////////////////////////////////////////////////
  wire cs_lvl;
  wire sck_rise;
  wire sck_fall;
  wire si_lvl;
  wire wp_lvl;
  wire cs_rise;
  edge_sync u_cs (.core_clk(core_clk), .rst_b(rst_b), .pin(cs_b), .rst_val(1'b1),
    .level(cs_lvl), .rise(cs_rise), .fall());
  // Mode 0 idles low; a mode 3 master leaves one harmless edge while deselected
  edge_sync u_sck (.core_clk(core_clk), .rst_b(rst_b), .pin(sck), .rst_val(1'b0),
    .level(), .rise(sck_rise), .fall(sck_fall));
  edge_sync u_si (.core_clk(core_clk), .rst_b(rst_b), .pin(si), .rst_val(1'b1),
    .level(si_lvl), .rise(), .fall());
  edge_sync u_wp (.core_clk(core_clk), .rst_b(rst_b), .pin(wp_b), .rst_val(1'b1),
    .level(wp_lvl), .rise(), .fall());

  function prot_hit;
    input [1:0] bp;
    input [17:0] a;
    begin
      case (bp)
        2'b01: prot_hit = (a >= `PROT_Q3_BASE);
        2'b10: prot_hit = (a >= `PROT_HALF_BASE);
        2'b11: prot_hit = 1'b1;
        default: prot_hit = 1'b0;
      endcase
    end
  endfunction

  function id_sel_lock;
    input [17:0] a;
    begin
      id_sel_lock = a[`ADDR_LOCK_SEL];
    end
  endfunction

  // Past the first data byte the count folds back by one byte, so byte
  // boundaries stay visible however long a write burst runs
  function [5:0] bits_step;
    input [5:0] b;
    begin
      if (b == `BITS_WRAP_TOP)
        bits_step = `BITS_WRAP_BASE;
      else
        bits_step = b + 6'h1;
    end
  endfunction

  // Latch commands are honoured at one or two whole bytes only
  function latch_len_ok;
    input [5:0] b;
    begin
      latch_len_ok = (b == `BITS_OP) || (b == `BITS_OP_DATA);
    end
  endfunction

  // Array and id writes need opcode, address and at least one whole data byte
  function has_data_byte;
    input [5:0] b;
    begin
      has_data_byte = (b > `BITS_OP_ADDR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [5:0] bits_ff;
  reg [31:0] shift_ff;
  reg [6:0] op_ff;
  reg wel_ff;
  reg [1:0] bp_ff;
  reg pen_ff;
  reg [1:0] bp_pend_ff;
  reg pen_pend_ff;
  reg stat_pend_ff;
  reg [31:0] wcnt_ff;
  reg [7:0] out_ff;
  reg [2:0] obit_ff;
  wire hw_prot = pen_ff & ~wp_lvl;
  wire [31:0] shifted = {shift_ff[30:0], si_lvl};
  wire [6:0] op_now = {shifted[7:4], shifted[2:0]};
  assign busy = (wcnt_ff != 32'h0);
  wire [7:0] stat_raw = {pen_ff, 3'b000, bp_ff, wel_ff, 1'b0};
  assign status = busy ? 8'hff : stat_raw;
  // A frame takes effect only on a byte boundary, and never after a refused opcode
  wire commit_ok = cs_rise && !busy && state_ff != S_IGN && bits_ff[2:0] == 3'h0;

  function op_known;
    input [6:0] o;
    begin
      case (o)
        `OP_SET_WEL, `OP_CLR_WEL, `OP_RD_STAT, `OP_WR_STAT,
        `OP_RD_ARR, `OP_WR_ARR, `OP_RD_ID, `OP_WR_ID: op_known = 1'b1;
        default: op_known = 1'b0;
      endcase
    end
  endfunction

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_OPC: begin
        if (sck_rise && bits_ff == `BITS_OP - 6'h1) begin
          if (!op_known(op_now) || (busy && op_now != `OP_RD_STAT))
            nxt_state = S_IGN;
          else if (op_now == `OP_RD_STAT)
            nxt_state = S_OUT;
          else if (op_now == `OP_SET_WEL || op_now == `OP_CLR_WEL || op_now == `OP_WR_STAT)
            nxt_state = S_DATA;
          else
            nxt_state = S_ADDR;
        end
      end
      S_ADDR: begin
        if (sck_rise && bits_ff == `BITS_OP_ADDR - 6'h1)
          nxt_state = S_DATA;
      end
      S_DATA, S_OUT, S_IGN: nxt_state = state_ff;
      default: nxt_state = S_OPC;
    endcase
    if (cs_lvl)
      nxt_state = S_OPC;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (!rst_b) begin
      state_ff <= S_OPC;
      bits_ff <= 6'h0;
      shift_ff <= 32'h0;
      op_ff <= 7'h0;
      wel_ff <= 1'b0;
      bp_ff <= 2'b00;
      pen_ff <= 1'b0;
      bp_pend_ff <= 2'b00;
      pen_pend_ff <= 1'b0;
      stat_pend_ff <= 1'b0;
      wcnt_ff <= 32'h0;
      out_ff <= 8'h0;
      obit_ff <= 3'h0;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
      arr_addr_ff <= 18'h0;
      id_index_ff <= 8'h0;
      arr_rd_start_ff <= 1'b0;
      arr_wr_start_ff <= 1'b0;
      id_rd_start_ff <= 1'b0;
      id_wr_start_ff <= 1'b0;
      id_lock_start_ff <= 1'b0;
      lock_rd_start_ff <= 1'b0;
      wr_data_ff <= 8'h0;
    end else begin
      state_ff <= nxt_state;
      arr_rd_start_ff <= 1'b0;
      arr_wr_start_ff <= 1'b0;
      id_rd_start_ff <= 1'b0;
      id_wr_start_ff <= 1'b0;
      id_lock_start_ff <= 1'b0;
      lock_rd_start_ff <= 1'b0;
      // Self-timed cycle; status fields commit only at its end
      if (wcnt_ff != 32'h0) begin
        wcnt_ff <= wcnt_ff - 32'h1;
        if (wcnt_ff == 32'h1 && stat_pend_ff) begin
          bp_ff <= bp_pend_ff;
          pen_ff <= pen_pend_ff;
          stat_pend_ff <= 1'b0;
        end
      end
      if (cs_lvl) begin
        bits_ff <= 6'h0;
        so_oe_ff <= 1'b0;
      end else if (sck_rise) begin
        shift_ff <= shifted;
        bits_ff <= bits_step(bits_ff);
        if (bits_ff == `BITS_OP - 6'h1) begin
          op_ff <= op_now;
          out_ff <= status;
          obit_ff <= 3'h7;
        end
        if (state_ff == S_ADDR && bits_ff == `BITS_OP_ADDR - 6'h1) begin
          arr_addr_ff <= shifted[17:0];
          id_index_ff <= shifted[7:0];
          if (op_ff == `OP_RD_ARR)
            arr_rd_start_ff <= 1'b1;
          if (op_ff == `OP_RD_ID) begin
            id_rd_start_ff <= ~shifted[`ADDR_LOCK_SEL];
            lock_rd_start_ff <= shifted[`ADDR_LOCK_SEL];
          end
        end
        if (state_ff == S_DATA && bits_ff[2:0] == 3'h7)
          wr_data_ff <= shifted[7:0];
      end else if (sck_fall && state_ff == S_OUT) begin
        // Reload each byte so the repeat shows the live value
        so_oe_ff <= 1'b1;
        so_ff <= out_ff[obit_ff];
        obit_ff <= obit_ff - 3'h1;
        if (obit_ff == 3'h0)
          out_ff <= status;
      end
      // Commit happens on deselect, only at a clean byte boundary
      if (commit_ok) begin
        case (op_ff)
          `OP_SET_WEL: begin
            if (latch_len_ok(bits_ff))
              wel_ff <= 1'b1;
          end
          `OP_CLR_WEL: begin
            if (latch_len_ok(bits_ff))
              wel_ff <= 1'b0;
          end
          `OP_WR_STAT: begin
            if (bits_ff == `BITS_OP_DATA) begin
              wel_ff <= 1'b0;
              if (wel_ff && !hw_prot) begin
                bp_pend_ff <= {shift_ff[`ST_BP_HI], shift_ff[`ST_BP_LO]};
                // Protect enable cannot drop while the pin is low
                pen_pend_ff <= (pen_ff && !wp_lvl) ? 1'b1 : shift_ff[`ST_PEN];
                stat_pend_ff <= 1'b1;
                wcnt_ff <= WRITE_CYCLES;
              end
            end
          end
          `OP_WR_ARR: begin
            if (has_data_byte(bits_ff)) begin
              wel_ff <= 1'b0;
              if (wel_ff && !prot_hit(bp_ff, arr_addr_ff)) begin
                arr_wr_start_ff <= 1'b1;
                wcnt_ff <= WRITE_CYCLES;
              end
            end
          end
          `OP_WR_ID: begin
            if (has_data_byte(bits_ff) && wel_ff && bp_ff != 2'b11) begin
              id_wr_start_ff <= ~id_sel_lock(arr_addr_ff);
              id_lock_start_ff <= id_sel_lock(arr_addr_ff);
              wcnt_ff <= WRITE_CYCLES;
            end
          end
          default: wel_ff <= wel_ff;
        endcase
      end
    end
  end

endmodule // eeprom_ctl

/* File: core/eeprom_ctl_consts.vh */
// Constants for the serial EEPROM instruction and protection block
`ifndef EEPROM_CTL_CONSTS_VH
`define EEPROM_CTL_CONSTS_VH
`define OP_SET_WEL 7'h06
`define OP_CLR_WEL 7'h04
`define OP_RD_STAT 7'h05
`define OP_WR_STAT 7'h01
`define OP_RD_ARR 7'h03
`define OP_WR_ARR 7'h02
`define OP_RD_ID 7'h43
`define OP_WR_ID 7'h42
`define ST_BUSY 0
`define ST_WEL 1
`define ST_BP_LO 2
`define ST_BP_HI 3
`define ST_PEN 7
`define ADDR_LOCK_SEL 10
`define PROT_Q3_BASE 18'h30000
`define PROT_HALF_BASE 18'h20000
`define BITS_OP 6'h08
`define BITS_OP_ADDR 6'h20
`define BITS_OP_DATA 6'h10
`define BITS_WRAP_BASE 6'h28
`define BITS_WRAP_TOP 6'h2f
`define WRITE_CYCLE_NS 5000000
`define CLK_PERIOD_NS 4
`endif

/* File: core/edge_sync.v */
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps
module edge_sync (
  input wire core_clk,
  input wire rst_b,
  input wire pin,
  input wire rst_val,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      meta_ff <= rst_val;
      sync_ff <= rst_val;
      last_ff <= rst_val;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  // Reset to the pin's idle level so that no false edge follows reset
  assign level = sync_ff;
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;
endmodule // edge_sync

/* File: verification/eeprom_ctl_asserts.sv */
// Port assertions for the serial EEPROM control block
`timescale 1ns/1ps
module eeprom_ctl_asserts #(
  parameter WRITE_CYCLES = 20
) (
  input wire core_clk,
  input wire rst_b,
  input wire cs_b,
  input wire sck,
  input wire so_ff,
  input wire so_oe_ff,
  input wire [7:0] status,
  input wire arr_rd_start_ff,
  input wire arr_wr_start_ff,
  input wire busy
);
  // Busy length is counted here; a repetition that long would stall the tools
  int busy_cnt_ff;
  always @(posedge core_clk) begin
    busy_cnt_ff <= (!rst_b || !busy) ? 0 : busy_cnt_ff + 1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  property p_all_ones; busy |-> status == 8'hff; endproperty
  a_all_ones: assert property (p_all_ones) else $error("status not all ones while busy");
  property p_busy_len; $fell(busy) && $past(rst_b) |-> busy_cnt_ff == WRITE_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_wr_busy; arr_wr_start_ff |-> ##[0:3] busy; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("array write without busy");
  property p_latch_needed; $rose(busy) |-> $past(status[1]); endproperty
  a_latch_needed: assert property (p_latch_needed) else $error("write cycle without latch");
  property p_latch_rise; $rose(status[1]) && !busy && !$past(busy) |-> cs_b; endproperty
  a_latch_rise: assert property (p_latch_rise) else $error("latch set while selected");
  property p_fields_hold; !busy && !$past(busy) && $past(rst_b) |-> $stable(status[7:2]); endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("status fields moved outside write end");
  property p_so_fall; so_oe_ff && $past(so_oe_ff) && $changed(so_ff) |-> !sck; endproperty
  a_so_fall: assert property (p_so_fall) else $error("output bit changed with clock high");
  property p_idle_off; cs_b [*6] |-> !so_oe_ff; endproperty
  a_idle_off: assert property (p_idle_off) else $error("output driven while deselected");
  property p_rd_sel; arr_rd_start_ff |-> !cs_b; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("array read start while deselected");
endmodule // eeprom_ctl_asserts
bind eeprom_ctl eeprom_ctl_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) eeprom_ctl_asserts_inst (.core_clk(core_clk),
  .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .so_ff(so_ff), .so_oe_ff(so_oe_ff), .status(status),
  .arr_rd_start_ff(arr_rd_start_ff), .arr_wr_start_ff(arr_wr_start_ff), .busy(busy));

/* File: verification/spi_master_model.sv */
// Behavioural SPI master, mode 0, facing the EEPROM control block
`timescale 1ns/1ps
module spi_master_model (
  input wire core_clk,
  input wire so_ff,
  input wire so_oe_ff,
  output logic cs_b,
  output logic sck,
  output logic si
);
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Sends bits n-1 down to 0; the clock stands low outside frames
  task automatic xfer(input int n, input logic [39:0] tx, output logic [39:0] rx);
    rx = 40'h0;
    @(posedge core_clk);
    #1 cs_b = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #24 sck = 1'b1;
      // A released output shows the inverse of the last bit, never a lucky settle
      rx = {rx[38:0], so_oe_ff ? so_ff : ~rx[0]};
      #24 sck = 1'b0;
    end
    #24 cs_b = 1'b1;
    si = ~si;
    #40;
  endtask
endmodule // spi_master_model

/* File: verification/testbench.sv */
// Self-checking bench for the serial EEPROM control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module testbench;
  localparam int WC = 600;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  wire cs_b, sck, si, so_ff, so_oe_ff, busy, arr_rd_start_ff, arr_wr_start_ff;
  wire id_rd_start_ff, id_wr_start_ff, id_lock_start_ff, lock_rd_start_ff;
  wire [7:0] status, id_index_ff, wr_data_ff;
  wire [17:0] arr_addr_ff;
  int n_errors = 0;
  int n_checks = 0;
  int n_oe = 0;
  int n_st [6];
  logic [39:0] rx;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    n_oe <= n_oe + so_oe_ff;
    n_st[0] <= n_st[0] + arr_rd_start_ff;
    n_st[1] <= n_st[1] + arr_wr_start_ff;
    n_st[2] <= n_st[2] + id_rd_start_ff;
    n_st[3] <= n_st[3] + lock_rd_start_ff;
    n_st[4] <= n_st[4] + id_wr_start_ff;
    n_st[5] <= n_st[5] + id_lock_start_ff;
  end
  eeprom_ctl #(.WRITE_CYCLES(WC)) eeprom_ctl_inst (.core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b),
    .sck(sck), .si(si), .wp_b(wp_b), .so_ff(so_ff), .so_oe_ff(so_oe_ff), .status(status),
    .arr_addr_ff(arr_addr_ff), .id_index_ff(id_index_ff), .arr_rd_start_ff(arr_rd_start_ff),
    .arr_wr_start_ff(arr_wr_start_ff), .id_rd_start_ff(id_rd_start_ff), .id_wr_start_ff(id_wr_start_ff),
    .id_lock_start_ff(id_lock_start_ff), .lock_rd_start_ff(lock_rd_start_ff), .wr_data_ff(wr_data_ff),
    .busy(busy));
  spi_master_model spi_master_model_inst (.core_clk(core_clk), .so_ff(so_ff), .so_oe_ff(so_oe_ff),
    .cs_b(cs_b), .sck(sck), .si(si));
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task send(input int n, input logic [39:0] tx);
    spi_master_model_inst.xfer(n, tx, rx);
  endtask
  task wait_idle;
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK("busy", 1'b0, busy)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_latch;
    `CHK("status", 8'h00, status)
    send(8, 40'h06);
    `CHK("latch", 1'b1, status[1])
    send(16, 40'h04a5);
    `CHK("latch", 1'b0, status[1])
    send(16, 40'h065a);
    `CHK("latch", 1'b1, status[1])
    send(8, 40'h0c);
    `CHK("latch", 1'b0, status[1])
    send(8, 40'h0e);
    send(24, 40'h050000);
    `CHK("read_status_cmd", 16'h0202, rx[15:0])
    `CHK("so_oe", 1'b0, so_oe_ff)
  endtask
  task t_write_status_cmd;
    send(16, 40'h01fc);
    `CHK("status", 8'hff, status)
    send(24, 40'h050000);
    `CHK("read_status_cmd", 16'hffff, rx[15:0])
    send(8, 40'h06);
    wait_idle;
    `CHK("status", 8'h8c, status)
    wp_b = 1'b0;
    send(8, 40'h06);
    send(16, 40'h0100);
    `CHK("busy", 1'b0, busy)
    `CHK("fields", 6'h23, status[7:2])
    wp_b = 1'b1;
    send(8, 40'h06);
    send(16, 40'h0104);
    wait_idle;
    `CHK("status", 8'h04, status)
  endtask
  task t_array;
    send(8, 40'h06);
    send(40, 40'h02c30010a5);
    `CHK("wr_start", 0, n_st[1])
    `CHK("latch", 1'b0, status[1])
    send(8, 40'h06);
    send(40, 40'h02c2fff05a);
    `CHK("wr_start", 1, n_st[1])
    `CHK("addr", 18'h2fff0, arr_addr_ff)
    `CHK("data", 8'h5a, wr_data_ff)
    wait_idle;
    send(32, 40'h03fe0005);
    `CHK("rd_start", 1, n_st[0])
    `CHK("addr", 18'h20005, arr_addr_ff)
    send(32, 40'h8bfffb5a);
    `CHK("id_start", 1, n_st[2])
    `CHK("index", 8'h5a, id_index_ff)
    send(32, 40'h83000400);
    `CHK("lock_start", 1, n_st[3])
  endtask
  task t_id;
    send(8, 40'h06);
    send(40, 40'h8200002a3c);
    `CHK("idw_start", 1, n_st[4])
    `CHK("index", 8'h2a, id_index_ff)
    send(32, 40'h03000000);
    `CHK("rd_start", 1, n_st[0])
    wait_idle;
    send(8, 40'h06);
    send(40, 40'h8200040002);
    `CHK("lock_start", 1, n_st[5])
    `CHK("data", 8'h02, wr_data_ff)
    wait_idle;
  endtask
  task t_undef;
    int k;
    k = n_oe;
    send(24, 40'h20ffff);
    `CHK("oe_cycles", 0, n_oe - k)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    t_latch;
    t_write_status_cmd;
    t_array;
    t_id;
    t_undef;
    end_of_test;
  end
  // Whole run is about 40 us; anything far beyond is a hang
  initial begin
    #150000;
    n_errors++;
    end_of_test;
  end
endmodule // testbench
